/* rtl/arsr_map.vh */
// register map for the audio routing select register bank
// assumes byte addressing on a 32-bit bus, one register per word
`ifndef ARSR_MAP_VH
`define ARSR_MAP_VH
// ----------------------------------------
// register offsets (word indexes)
// ----------------------------------------
`define ARSR_OFS_START_SLOT 8'h17
`define ARSR_OFS_SRC_01 8'h18
`define ARSR_OFS_SRC_23 8'h19
// printed offsets are not word aligned, so byte address is index times four
`define ARSR_ADDR_START_SLOT 10'h05c
`define ARSR_ADDR_SRC_01 10'h060
`define ARSR_ADDR_SRC_23 10'h064
// ----------------------------------------
// reset values
// ----------------------------------------
`define ARSR_RST_START_SLOT 8'h04
`define ARSR_RST_SRC_01 8'h10
`define ARSR_RST_SRC_23 8'h32
// ----------------------------------------
// field positions
// ----------------------------------------
`define ARSR_LINE0_LSB 0
`define ARSR_LINE1_LSB 2
`define ARSR_SRC_LO_LSB 0
`define ARSR_SRC_HI_LSB 4
`define ARSR_START_MASK 8'h0f
// source code groups: top bits of a four-bit source code
`define ARSR_GRP_CORE 2'b00
`define ARSR_GRP_CONV 2'b01
`define ARSR_RESP_OKAY 1'b0
`endif

/* rtl/arsr_shadow.v */
// frame-aligned shadow copy of one routing register
// assumes frame_start is a one-cycle pulse on the same clock
`timescale 1ns/1ps
`default_nettype none
module arsr_shadow #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire frame_start,
  input wire [WIDTH-1:0] staged,
  output reg [WIDTH-1:0] active
);
  // new setting only lands at a frame boundary, so no frame mixes routes
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active <= RESET_VALUE;
    end else if (frame_start) begin
      active <= staged;
    end
  end
endmodule // arsr_shadow
`default_nettype wire

/* rtl/arsr_regs.v */
// audio routing select register bank with AHB-Lite slave port
// assumes a single clock domain; frame_start from the serial port framer
`timescale 1ns/1ps
`default_nettype none
`include "arsr_map.vh"
module arsr_regs (
  input wire clk,
  input wire rst_n,
  input wire hsel,
  input wire [9:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire frame_start,
  input wire channel_sequencing_bit,
  output reg [2:0] first_line_start_slot,
  output reg [2:0] second_line_start_slot,
  output reg first_line_seq_mode,
  output reg second_line_seq_mode,
  output reg [3:0] out_conv_ch0_source,
  output reg [3:0] out_conv_ch1_source,
  output reg [3:0] out_conv_ch2_source,
  output reg [3:0] out_conv_ch3_source,
  output reg [3:0] out_conv_src_is_core,
  output reg [3:0] out_conv_src_is_conv
);
  // ----------------------------------------
  // reset release and local state
  // ----------------------------------------
  reg rst_meta;
  reg rst_sync_n;
  reg [7:0] start_slot_reg;
  reg [7:0] src01_reg;
  reg [7:0] src23_reg;
  reg wr_pend;
  reg [9:0] wr_addr;
  reg frame_q;
  wire [7:0] start_act;
  wire [7:0] src01_act;
  wire [7:0] src23_act;
  wire [15:0] src_all;
  wire take;
  reg [7:0] rd_val;

  // routing reset values follow the register reset values, so the two cannot drift apart
  localparam [7:0] RST_START = `ARSR_RST_START_SLOT;
  localparam [7:0] RST_SRC01 = `ARSR_RST_SRC_01;
  localparam [7:0] RST_SRC23 = `ARSR_RST_SRC_23;
  localparam [15:0] RST_SRC_ALL = {RST_SRC23, RST_SRC01};

  // slot code n maps to channel 2n
  function [2:0] slot_of;
    input [1:0] code;
    begin
      slot_of = {code, 1'b0};
    end
  endfunction

  // top two bits of a source code name its group
  function [1:0] grp_of;
    input [3:0] code;
    begin
      grp_of = code[3:2];
    end
  endfunction

  // reset is asserted at once but released through two flops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  assign take = hsel & hready & htrans[1];

  // address phase is latched, write lands in the data phase
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 10'h000;
      hreadyout <= 1'b1;
      hresp <= `ARSR_RESP_OKAY;
    end else begin
      wr_pend <= take & hwrite;
      wr_addr <= haddr;
      hreadyout <= 1'b1; // zero wait states, always OKAY
      hresp <= `ARSR_RESP_OKAY;
    end
  end

  // register writes; unmapped addresses are ignored, start slot reserved bits 7:4 kept zero
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      start_slot_reg <= `ARSR_RST_START_SLOT;
      src01_reg <= `ARSR_RST_SRC_01;
      src23_reg <= `ARSR_RST_SRC_23;
    end else if (wr_pend) begin
      case (wr_addr)
        `ARSR_ADDR_START_SLOT: start_slot_reg <= hwdata[7:0] & `ARSR_START_MASK;
        `ARSR_ADDR_SRC_01: src01_reg <= hwdata[7:0];
        `ARSR_ADDR_SRC_23: src23_reg <= hwdata[7:0];
        default: start_slot_reg <= start_slot_reg;
      endcase
    end
  end

  // read mux; staged value is what software reads back
  always @* begin
    case (haddr)
      `ARSR_ADDR_START_SLOT: rd_val = start_slot_reg;
      `ARSR_ADDR_SRC_01: rd_val = src01_reg;
      `ARSR_ADDR_SRC_23: rd_val = src23_reg;
      default: rd_val = 8'h00;
    endcase
  end

  // read data registered at address phase, valid in data phase
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hrdata <= 32'h00000000;
    end else if (take & ~hwrite) begin
      hrdata <= {24'h000000, rd_val};
    end
  end

  // ----------------------------------------
  // frame-aligned active copies
  // ----------------------------------------
  arsr_shadow #(.WIDTH(8), .RESET_VALUE(`ARSR_RST_START_SLOT)) u_sh_start (
    .clk(clk),
    .rst_n(rst_sync_n),
    .frame_start(frame_q),
    .staged(start_slot_reg),
    .active(start_act)
  );
  arsr_shadow #(.WIDTH(8), .RESET_VALUE(`ARSR_RST_SRC_01)) u_sh_src01 (
    .clk(clk),
    .rst_n(rst_sync_n),
    .frame_start(frame_q),
    .staged(src01_reg),
    .active(src01_act)
  );
  arsr_shadow #(.WIDTH(8), .RESET_VALUE(`ARSR_RST_SRC_23)) u_sh_src23 (
    .clk(clk),
    .rst_n(rst_sync_n),
    .frame_start(frame_q),
    .staged(src23_reg),
    .active(src23_act)
  );

  assign src_all = {src23_act, src01_act};

  // frame pulse delayed one cycle so a write in that cycle still lands
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      frame_q <= 1'b0;
    end else begin
      frame_q <= frame_start;
    end
  end

  // ----------------------------------------
  // routing outputs
  // ----------------------------------------
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      first_line_start_slot <= {RST_START[`ARSR_LINE0_LSB +: 2], 1'b0};
      second_line_start_slot <= {RST_START[`ARSR_LINE1_LSB +: 2], 1'b0};
      first_line_seq_mode <= 1'b0;
      second_line_seq_mode <= 1'b0;
      out_conv_ch0_source <= RST_SRC01[`ARSR_SRC_LO_LSB +: 4];
      out_conv_ch1_source <= RST_SRC01[`ARSR_SRC_HI_LSB +: 4];
      out_conv_ch2_source <= RST_SRC23[`ARSR_SRC_LO_LSB +: 4];
      out_conv_ch3_source <= RST_SRC23[`ARSR_SRC_HI_LSB +: 4];
    end else begin
      first_line_start_slot <= slot_of(start_act[`ARSR_LINE0_LSB +: 2]);
      second_line_start_slot <= slot_of(start_act[`ARSR_LINE1_LSB +: 2]);
      // sequencing is passed through so the framer steps channels from the start
      first_line_seq_mode <= channel_sequencing_bit;
      second_line_seq_mode <= channel_sequencing_bit;
      out_conv_ch0_source <= src01_act[`ARSR_SRC_LO_LSB +: 4];
      out_conv_ch1_source <= src01_act[`ARSR_SRC_HI_LSB +: 4];
      out_conv_ch2_source <= src23_act[`ARSR_SRC_LO_LSB +: 4];
      out_conv_ch3_source <= src23_act[`ARSR_SRC_HI_LSB +: 4];
    end
  end

  // per-channel source group decode; serial inputs are codes with bit 3 set
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_grp
      always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          out_conv_src_is_core[g] <= (RST_SRC_ALL[g*4+2 +: 2] == `ARSR_GRP_CORE);
          out_conv_src_is_conv[g] <= (RST_SRC_ALL[g*4+2 +: 2] == `ARSR_GRP_CONV);
        end else begin
          out_conv_src_is_core[g] <= (grp_of(src_all[g*4 +: 4]) == `ARSR_GRP_CORE);
          out_conv_src_is_conv[g] <= (grp_of(src_all[g*4 +: 4]) == `ARSR_GRP_CONV);
        end
      end
    end
  endgenerate
endmodule // arsr_regs
`default_nettype wire

/* test/arsr_regs_properties.sv */
// checker for the routing select bank, bound to its top module
// assumes one clock and the raw active-low reset on the ports
`timescale 1ns/1ps
`default_nettype none
module arsr_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic frame_start,
  input wire logic channel_sequencing_bit,
  input wire logic [2:0] first_line_start_slot,
  input wire logic [2:0] second_line_start_slot,
  input wire logic first_line_seq_mode,
  input wire logic [3:0] out_conv_ch0_source,
  input wire logic [3:0] out_conv_ch1_source,
  input wire logic [3:0] out_conv_ch2_source,
  input wire logic [3:0] out_conv_ch3_source,
  input wire logic [3:0] out_conv_src_is_core,
  input wire logic [3:0] out_conv_src_is_conv
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // outputs still at reset while the synchroniser holds the core
  rst_val_a: assert property ($rose(rst_n) |-> second_line_start_slot == 3'h2
    && out_conv_ch1_source == 4'h1 && out_conv_ch3_source == 4'h3)
    else $error("routing outputs not at reset values");
  slot_even_a: assert property (!first_line_start_slot[0]
    && !second_line_start_slot[0]) else $error("start slot is odd");
  // staged writes reach the outputs only behind a frame pulse
  slot_frame_a: assert property ($changed(second_line_start_slot) |->
    $past(frame_start, 2) || $past(frame_start, 3)) else $error("slot moved off frame");
  src_frame_a: assert property ($changed(out_conv_ch2_source) |->
    $past(frame_start, 2) || $past(frame_start, 3)) else $error("source moved off frame");
  seq_follow_a: assert property ($changed(channel_sequencing_bit) |=>
    first_line_seq_mode == $past(channel_sequencing_bit)) else $error("seq mode lag");
  // decode updates on the same edge as its source; judged only while the source is stable
  core_dec_a: assert property ($stable(out_conv_ch0_source) |->
    out_conv_src_is_core[0] == (out_conv_ch0_source[3:2] == 2'b00)) else $error("core decode");
  conv_dec_a: assert property ($stable(out_conv_ch1_source) |->
    out_conv_src_is_conv[1] == (out_conv_ch1_source[3:2] == 2'b01)) else $error("conv decode");
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("wait state or error response");
  rdata_width_a: assert property (hrdata[31:8] == 24'h0)
    else $error("read data wider than eight bits");
  frame_c: cover property (frame_start);
  write_c: cover property (hsel && htrans[1] && hwrite);
  serial_c: cover property (out_conv_ch1_source[3]);
endmodule // arsr_chk
bind arsr_regs arsr_chk u_chk (.*);
`default_nettype wire

/* test/test_audio_route_select_regs.sv */
// bench for the routing select bank: AHB-Lite tasks and scenarios
// assumes the bank signals readiness on hreadyout, fed back as hready
`timescale 1ns/1ps
`default_nettype none
`include "arsr_map.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_audio_route_select_regs;
  logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, frame_start = 1'b0, csb = 1'b0;
  logic [9:0] haddr = 10'h000;
  logic [1:0] htrans = 2'b00;
  logic [31:0] hwdata = 32'h0;
  int bad_count = 0, n_checks = 0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, fm, sm;
  wire [2:0] fs, ss;
  wire [3:0] s0, s1, s2, s3, ic, iv;
  always #2 clk = ~clk;
  arsr_regs DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .frame_start(frame_start),
    .channel_sequencing_bit(csb), .first_line_start_slot(fs), .second_line_start_slot(ss),
    .first_line_seq_mode(fm), .second_line_seq_mode(sm), .out_conv_ch0_source(s0),
    .out_conv_ch1_source(s1), .out_conv_ch2_source(s2), .out_conv_ch3_source(s3),
    .out_conv_src_is_core(ic), .out_conv_src_is_conv(iv));
  // ----------------------------------------
  // bus and frame helpers
  // ----------------------------------------
  // one single transfer; the gap before the next one keeps read-after-write safe
  task automatic xfer(input logic [9:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(a, 1'b0, 32'h0, q);
    `CHK(q, e)
  endtask
  task automatic frame;
    @(posedge clk) frame_start <= 1'b1;
    @(posedge clk) frame_start <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    `CHK({fs, ss, s3, s2, s1, s0}, {3'h0, 3'h2, 16'h3210})
    rdchk(`ARSR_ADDR_START_SLOT, 32'h04);
    rdchk(`ARSR_ADDR_SRC_01, 32'h10);
    rdchk(`ARSR_ADDR_SRC_23, 32'h32);
    $display("done reset values");
  endtask
  // every slot and source code, outputs held until the frame pulse
  task automatic t_route;
    logic [3:0] i, j;
    logic [31:0] q;
    logic [21:0] old;
    old = {3'h0, 3'h2, 16'h3210};
    for (int k = 0; k < 16; k++) begin
      i = k[3:0];
      j = ~i;
      xfer(`ARSR_ADDR_START_SLOT, 1'b1, {24'h0, 4'hf, i}, q);
      xfer(`ARSR_ADDR_SRC_01, 1'b1, {24'h0, i, j}, q);
      xfer(`ARSR_ADDR_SRC_23, 1'b1, {24'h0, j, i}, q);
      rdchk(`ARSR_ADDR_START_SLOT, {28'h0, i});
      rdchk(`ARSR_ADDR_SRC_01, {24'h0, i, j});
      rdchk(`ARSR_ADDR_SRC_23, {24'h0, j, i});
      `CHK({fs, ss, s3, s2, s1, s0}, old)
      frame;
      old = {i[1:0], 1'b0, i[3:2], 1'b0, j, i, i, j};
      `CHK({fs, ss, s3, s2, s1, s0}, old)
      `CHK(ic, {j[3:2] == 2'b00, i[3:2] == 2'b00, i[3:2] == 2'b00, j[3:2] == 2'b00})
      `CHK(iv, {j[3:2] == 2'b01, i[3:2] == 2'b01, i[3:2] == 2'b01, j[3:2] == 2'b01})
    end
    $display("done routing codes");
  endtask
  task automatic t_unmapped;
    logic [31:0] q;
    xfer(10'h068, 1'b1, 32'hff, q);
    rdchk(10'h068, 32'h0);
    rdchk(`ARSR_ADDR_SRC_23, {24'h0, 8'h0f});
    $display("done unmapped");
  endtask
  task automatic t_seq;
    @(posedge clk) csb <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK({fm, sm}, 2'b11)
    csb <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({fm, sm}, 2'b00)
    $display("done sequencing copy");
  endtask
  task print_verdict;
    $display("checks=%0d bad=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog: the tests need a few hundred cycles at most
  initial begin
    #40000;
    bad_count++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_route;
    t_unmapped;
    t_seq;
    print_verdict;
  end
endmodule // test_audio_route_select_regs
`default_nettype wire
